// ---- logic/ltm_pkg.sv ----
// Package of the LIN transceiver mode control block.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
package ltm_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned ENABLE_TIME_NS   = 10000;
	localparam int unsigned WAKE_FILTER_NS   = 30000;
	localparam int unsigned TX_TIMEOUT_NS    = 20000000;
	localparam int unsigned BUS_TIMEOUT_NS   = 20000000;
	// Least times round up to whole cycles
	localparam int unsigned ENABLE_CYC       = (ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAKE_FILTER_CYC  = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TX_TIMEOUT_CYC   = (TX_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BUS_TIMEOUT_CYC  = (BUS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W            = 24;

	// ----------------------------------------
	// Event buffer
	// ----------------------------------------
	localparam int unsigned EV_DEPTH         = 16;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		LTM_MODE_OFF    = 2'h0,
		LTM_MODE_WAKE   = 2'h1,
		LTM_MODE_RXONLY = 2'h2,
		LTM_MODE_NORMAL = 2'h3
	} ltm_mode_t;

	typedef enum logic [4:0] {
		LTM_CHIP_NORMAL   = 5'h01,
		LTM_CHIP_STOP     = 5'h02,
		LTM_CHIP_SLEEP    = 5'h04,
		LTM_CHIP_RESTART  = 5'h08,
		LTM_CHIP_FAILSAFE = 5'h10
	} ltm_chip_t;

	typedef enum logic [1:0] {
		LTM_EV_WAKE     = 2'h1,
		LTM_EV_TX_TO    = 2'h2,
		LTM_EV_BUS_CLMP = 2'h3
	} ltm_ev_kind_t;

	typedef struct packed {
		ltm_ev_kind_t kind;
		ltm_chip_t    chip;
	} ltm_event_t;

	localparam int unsigned EV_W             = $bits(ltm_event_t);

	// Reset values
	localparam ltm_mode_t   MODE_RST         = LTM_MODE_OFF;
	localparam logic        SLOPE_LOW_RST    = 1'b0;
	localparam logic        FAST_PROG_RST    = 1'b0;

endpackage : ltm_pkg

// ---- logic/ltm_fifo.sv ----
// Event buffer with a registered output stage.
// Assumes one clock; srst is synchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module ltm_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             load;
	logic             mem_wr;
	logic             mem_rd;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	assign load     = !out_valid || out_ready;
	assign mem_rd   = load && (cnt_q != '0);
	assign mem_wr   = push && !(load && (cnt_q == '0));

	// ----------------------------------------
	// Storage and pointers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (mem_wr) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (mem_wr) begin
				wr_q <= wr_q + 1'b1;
			end
			if (mem_rd) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(mem_wr) - (AW+1)'(mem_rd);
		end
	end

	// ----------------------------------------
	// Output register, bypass when storage empty
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (load) begin
			if (mem_rd) begin
				out_valid <= 1'b1;
				out_data  <= mem_q[rd_q];
			end else begin
				out_valid <= push;
				out_data  <= in_data;
			end
		end
	end

endmodule : ltm_fifo
`default_nettype wire

// ---- logic/ltm_lin_ctrl.sv ----
// Digital control of the single-wire LIN transceiver: modes, wake, timeouts.
// Assumes all inputs synchronous to clock; bus_level is the receiver comparator.
`timescale 1ns/1ps
`default_nettype none

module ltm_lin_ctrl
	import ltm_pkg::*;
#(
	parameter int unsigned WAKE_CYC   = WAKE_FILTER_CYC,
	parameter int unsigned TXTO_CYC   = TX_TIMEOUT_CYC,
	parameter int unsigned BUSTO_CYC  = BUS_TIMEOUT_CYC,
	parameter int unsigned ENABLE_CNT = ENABLE_CYC
) (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire ltm_chip_t  chip_mode,
	input  wire logic       mode_wr,
	input  wire ltm_mode_t  mode_wdata,
	input  wire logic       cfg_wr,
	input  wire logic       low_slope_wdata,
	input  wire logic       fast_prog_wdata,
	input  wire logic       spi_cs_n,
	input  wire logic       watchdog_on_bus_wake,
	input  wire logic       watchdog_enabled,
	input  wire logic       lin_transmit_in,
	input  wire logic       bus_level,
	input  wire logic       supply_undervoltage,
	input  wire logic       fault_clear,
	input  wire logic       wake_clear,
	input  wire logic       ev_ready,
	output ltm_mode_t       lin_mode_field,
	output logic            lin_receive_pin,
	output logic            drv_enable,
	output logic            drv_dominant,
	output logic            low_slope_select,
	output logic            slope_ctrl_off,
	output logic            lin_fault_flag,
	output logic            wake_status_reg,
	output logic            int_req,
	output logic            watchdog_enable_req,
	output logic            chip_restart_req,
	output logic            ev_valid,
	output ltm_event_t      ev_data
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ltm_mode_t        mode_q;
	ltm_chip_t        chip_q;
	logic             uv;
	logic             chip_ns;
	logic             wr_ok;
	logic             rearm_chip;
	logic             mode_act;
	logic             tx_path;
	logic             rx_path;
	logic [CNT_W-1:0] en_cnt_q;
	logic             en_done_q;
	logic             tx_armed_q;
	logic [CNT_W-1:0] txd_cnt_q;
	logic             txd_to_q;
	logic [CNT_W-1:0] bus_cnt_q;
	logic             bus_clamp_q;
	logic [CNT_W-1:0] wk_cnt_q;
	logic             wk_armed_q;
	logic             wk_hold_q;
	logic             wake_hit;
	logic             txd_hit;
	logic             bus_hit;
	logic             low_pend_q;
	logic             fast_pend_q;
	logic             cs_n_q;
	ltm_event_t       ev_pend_q;
	logic             ev_pend_v_q;
	logic             ev_in_ready;
	ltm_event_t       ev_new;
	logic             ev_new_v;

	assign uv      = supply_undervoltage;
	assign chip_ns = (chip_mode == LTM_CHIP_NORMAL) || (chip_mode == LTM_CHIP_STOP);

	// ----------------------------------------
	// Mode field write qualification
	// ----------------------------------------
	always_comb begin
		case (mode_wdata)
			LTM_MODE_OFF:    wr_ok = 1'b1;
			LTM_MODE_NORMAL: wr_ok = (chip_mode == LTM_CHIP_NORMAL);
			LTM_MODE_RXONLY: wr_ok = chip_ns;
			LTM_MODE_WAKE:   wr_ok = (chip_mode != LTM_CHIP_FAILSAFE);
			default:         wr_ok = 1'b0;
		endcase
	end

	// Rearm on entry into Stop, Sleep or Fail-Safe
	assign rearm_chip = (chip_mode != chip_q) && ((chip_mode == LTM_CHIP_STOP) ||
		(chip_mode == LTM_CHIP_SLEEP) || (chip_mode == LTM_CHIP_FAILSAFE));

	// ----------------------------------------
	// Mode field
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			mode_q <= MODE_RST;
			chip_q <= LTM_CHIP_NORMAL;
		end else begin
			chip_q <= chip_mode;
			if (chip_mode == LTM_CHIP_FAILSAFE) begin
				mode_q <= LTM_MODE_WAKE;
			end else if (mode_wr && wr_ok) begin
				mode_q <= mode_wdata;
			end
		end
	end

	// Normal and receive-only act only while the chip is in Normal or Stop
	assign mode_act = chip_ns && ((mode_q == LTM_MODE_NORMAL) || (mode_q == LTM_MODE_RXONLY));
	assign rx_path  = mode_act && !uv;
	assign tx_path  = chip_ns && (mode_q == LTM_MODE_NORMAL) && !uv;

	// ----------------------------------------
	// Enabling delay and first dominant bit
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			en_cnt_q  <= '0;
			en_done_q <= 1'b0;
		end else if (!tx_path) begin
			en_cnt_q  <= '0;
			en_done_q <= 1'b0;
		end else if (!en_done_q) begin
			en_cnt_q  <= en_cnt_q + 1'b1;
			en_done_q <= (en_cnt_q == CNT_W'(ENABLE_CNT - 1));
		end
	end

	// Arms only on a recessive level seen after the delay
	always_ff @(posedge clock) begin
		if (srst) begin
			tx_armed_q <= 1'b0;
		end else if (!tx_path) begin
			tx_armed_q <= 1'b0;
		end else if (en_done_q && lin_transmit_in) begin
			tx_armed_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Transmit dominant timeout
	// ----------------------------------------
	assign txd_hit = tx_armed_q && !lin_transmit_in && !txd_to_q &&
		(txd_cnt_q == CNT_W'(TXTO_CYC));

	always_ff @(posedge clock) begin
		if (srst) begin
			txd_cnt_q <= '0;
			txd_to_q  <= 1'b0;
		end else if (!tx_armed_q || lin_transmit_in) begin
			txd_cnt_q <= '0;
			txd_to_q  <= 1'b0;
		end else begin
			if (txd_cnt_q != CNT_W'(TXTO_CYC)) begin
				txd_cnt_q <= txd_cnt_q + 1'b1;
			end
			if (txd_hit) begin
				txd_to_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Bus dominant clamp, any transceiver mode
	// ----------------------------------------
	assign bus_hit = !bus_level && !uv && !bus_clamp_q &&
		(bus_cnt_q == CNT_W'(BUSTO_CYC));

	always_ff @(posedge clock) begin
		if (srst) begin
			bus_cnt_q   <= '0;
			bus_clamp_q <= 1'b0;
		end else if (bus_level || uv) begin
			bus_cnt_q   <= '0;
			bus_clamp_q <= 1'b0;
		end else begin
			if (bus_cnt_q != CNT_W'(BUSTO_CYC)) begin
				bus_cnt_q <= bus_cnt_q + 1'b1;
			end
			if (bus_hit) begin
				bus_clamp_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Wake filter and rearming
	// ----------------------------------------
	assign wake_hit = (mode_q == LTM_MODE_WAKE) && wk_armed_q && !uv &&
		!bus_level && (wk_cnt_q == CNT_W'(WAKE_CYC));

	always_ff @(posedge clock) begin
		if (srst) begin
			wk_cnt_q <= '0;
		end else if (bus_level || (mode_q != LTM_MODE_WAKE) || !wk_armed_q || uv) begin
			wk_cnt_q <= '0;
		end else if (wk_cnt_q != CNT_W'(WAKE_CYC)) begin
			wk_cnt_q <= wk_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wk_armed_q <= 1'b1;
			wk_hold_q  <= 1'b0;
		end else if (mode_q != LTM_MODE_WAKE) begin
			wk_armed_q <= 1'b1;
			wk_hold_q  <= 1'b0;
		end else if (wake_hit) begin
			wk_armed_q <= 1'b0;
			wk_hold_q  <= 1'b1;
		end else if (rearm_chip) begin
			wk_armed_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			drv_enable      <= 1'b0;
			drv_dominant    <= 1'b0;
			lin_receive_pin <= 1'b1;
		end else begin
			drv_enable      <= tx_path && !txd_to_q && !txd_hit;
			drv_dominant    <= tx_path && tx_armed_q && !lin_transmit_in &&
				!txd_to_q && !txd_hit;
			if (wk_hold_q || wake_hit) begin
				lin_receive_pin <= 1'b0;
			end else if (rx_path) begin
				lin_receive_pin <= bus_level;
			end else begin
				lin_receive_pin <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Slope configuration, applied at chip select rising
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			low_pend_q       <= SLOPE_LOW_RST;
			fast_pend_q      <= FAST_PROG_RST;
			low_slope_select <= SLOPE_LOW_RST;
			slope_ctrl_off   <= FAST_PROG_RST;
			cs_n_q           <= 1'b1;
		end else begin
			cs_n_q <= spi_cs_n;
			if (cfg_wr && (chip_mode == LTM_CHIP_NORMAL)) begin
				low_pend_q  <= low_slope_wdata;
				fast_pend_q <= fast_prog_wdata;
			end
			if (spi_cs_n && !cs_n_q) begin
				low_slope_select <= low_pend_q;
				slope_ctrl_off   <= fast_pend_q;
			end
		end
	end

	// ----------------------------------------
	// Flags and chip-level wake effects
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			lin_fault_flag      <= 1'b0;
			wake_status_reg     <= 1'b0;
			int_req             <= 1'b0;
			watchdog_enable_req <= 1'b0;
			chip_restart_req    <= 1'b0;
			lin_mode_field      <= MODE_RST;
		end else begin
			lin_mode_field <= mode_q;
			if (txd_hit || bus_hit) begin
				lin_fault_flag <= 1'b1;
			end else if (fault_clear) begin
				lin_fault_flag <= 1'b0;
			end
			if (wake_hit) begin
				wake_status_reg <= 1'b1;
			end else if (wake_clear) begin
				wake_status_reg <= 1'b0;
			end
			int_req             <= wake_hit && chip_ns;
			watchdog_enable_req <= wake_hit && (chip_mode == LTM_CHIP_STOP) &&
				watchdog_on_bus_wake && !watchdog_enabled;
			chip_restart_req    <= wake_hit && ((chip_mode == LTM_CHIP_SLEEP) ||
				(chip_mode == LTM_CHIP_FAILSAFE));
		end
	end

	// ----------------------------------------
	// Event records into the buffer
	// ----------------------------------------
	always_comb begin
		ev_new_v  = wake_hit || txd_hit || bus_hit;
		ev_new    = '{kind: LTM_EV_WAKE, chip: chip_mode};
		if (txd_hit) begin
			ev_new.kind = LTM_EV_TX_TO;
		end else if (bus_hit) begin
			ev_new.kind = LTM_EV_BUS_CLMP;
		end
	end

	// One record waits here while the buffer is full; newer ones then drop
	always_ff @(posedge clock) begin
		if (srst) begin
			ev_pend_v_q <= 1'b0;
			ev_pend_q   <= '{kind: LTM_EV_WAKE, chip: LTM_CHIP_NORMAL};
		end else if (!ev_pend_v_q || ev_in_ready) begin
			ev_pend_v_q <= ev_new_v;
			ev_pend_q   <= ev_new;
		end
	end

	ltm_fifo #(
		.WIDTH (EV_W),
		.DEPTH (EV_DEPTH)
	) u_ev_fifo (
		.clock     (clock),
		.srst      (srst),
		.in_data   (ev_pend_q),
		.in_valid  (ev_pend_v_q),
		.in_ready  (ev_in_ready),
		.out_data  (ev_data),
		.out_valid (ev_valid),
		.out_ready (ev_ready)
	);

endmodule : ltm_lin_ctrl
`default_nettype wire

// ---- test/ltm_bus_model.sv ----
// Far-side model: remote LIN nodes on a wired-AND bus with a pull-up.
// Assumes drv_enable and drv_dominant come from the device under test.
`timescale 1ns/1ps
`default_nettype none
module ltm_bus_model (
	input  wire logic drv_enable,
	input  wire logic drv_dominant,
	input  wire logic remote_dom,
	output logic      bus_level
);
	// Recessive unless some node pulls low
	assign bus_level = !((drv_enable && drv_dominant) || remote_dom);
endmodule : ltm_bus_model
`default_nettype wire

// ---- test/ltm_lin_ctrl_monitor.sv ----
// Port checker of the LIN mode control block.
// Assumes one clock and a synchronous active-high srst; bound below.
`timescale 1ns/1ps
`default_nettype none
module ltm_lin_ctrl_chk
	import ltm_pkg::*;
#(
	parameter int unsigned TXTO_CYC = TX_TIMEOUT_CYC
) (
	input wire logic      clock,
	input wire logic      srst,
	input wire ltm_chip_t chip_mode,
	input wire logic      mode_wr,
	input wire ltm_mode_t mode_wdata,
	input wire logic      lin_transmit_in,
	input wire logic      bus_level,
	input wire logic      supply_undervoltage,
	input wire ltm_mode_t lin_mode_field,
	input wire logic      lin_receive_pin,
	input wire logic      drv_enable,
	input wire logic      drv_dominant,
	input wire logic      wake_status_reg,
	input wire logic      int_req,
	input wire logic      chip_restart_req
);
	int unsigned dom_cnt_q;
	always_ff @(posedge clock) begin
		if (srst || !drv_dominant) begin
			dom_cnt_q <= 0;
		end else begin
			dom_cnt_q <= dom_cnt_q + 1;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_reset_state: assert property (@(posedge clock) srst |=>
		lin_mode_field == LTM_MODE_OFF && lin_receive_pin && !drv_enable && !int_req)
		else $error("reset state wrong");
	a_mode_write: assert property (@(posedge clock) disable iff (srst)
		mode_wr && mode_wdata == LTM_MODE_OFF && chip_mode == LTM_CHIP_NORMAL ##1
		!mode_wr && chip_mode == LTM_CHIP_NORMAL |=> lin_mode_field == LTM_MODE_OFF)
		else $error("mode write not applied");
	a_off_no_wake: assert property (@(posedge clock) disable iff (srst)
		$rose(wake_status_reg) |-> lin_mode_field == LTM_MODE_WAKE)
		else $error("wake outside wake mode");
	a_drv_follow: assert property (@(posedge clock) disable iff (srst)
		drv_dominant |-> drv_enable && !$past(lin_transmit_in)) else $error("dominant without input");
	a_rx_follow: assert property (@(posedge clock) disable iff (srst)
		(lin_mode_field == LTM_MODE_NORMAL && chip_mode == LTM_CHIP_NORMAL && !supply_undervoltage)
		[*2] |-> lin_receive_pin == $past(bus_level)) else $error("receive pin not bus level");
	a_rxonly_no_drive: assert property (@(posedge clock) disable iff (srst)
		lin_mode_field == LTM_MODE_RXONLY [*2] |-> !drv_enable) else $error("driver on in rx only");
	a_wake_hold: assert property (@(posedge clock) disable iff (srst)
		!lin_receive_pin && lin_mode_field == LTM_MODE_WAKE ##1 lin_mode_field == LTM_MODE_WAKE
		|-> !lin_receive_pin) else $error("wake low not held");
	a_int_on_wake: assert property (@(posedge clock) disable iff (srst) int_req |->
		(wake_status_reg && !lin_receive_pin && ($past(chip_mode) == LTM_CHIP_NORMAL
		|| $past(chip_mode) == LTM_CHIP_STOP)) ##1 !int_req) else $error("bad interrupt");
	a_restart_sleep: assert property (@(posedge clock) disable iff (srst)
		chip_restart_req |-> !int_req && ($past(chip_mode) == LTM_CHIP_SLEEP
		|| $past(chip_mode) == LTM_CHIP_FAILSAFE)) else $error("bad restart request");
	a_tx_timeout: assert property (@(posedge clock) disable iff (srst)
		dom_cnt_q <= TXTO_CYC + 1) else $error("dominant past timeout");
	a_uv_gate: assert property (@(posedge clock) disable iff (srst)
		supply_undervoltage [*2] |-> !drv_enable && (lin_receive_pin
		|| lin_mode_field == LTM_MODE_WAKE || $past(lin_mode_field) == LTM_MODE_WAKE))
		else $error("undervoltage not gated");
endmodule : ltm_lin_ctrl_chk
bind ltm_lin_ctrl ltm_lin_ctrl_chk #(.TXTO_CYC(TXTO_CYC)) u_chk (.clock(clock), .srst(srst),
	.chip_mode(chip_mode), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
	.lin_transmit_in(lin_transmit_in), .bus_level(bus_level),
	.supply_undervoltage(supply_undervoltage), .lin_mode_field(lin_mode_field),
	.lin_receive_pin(lin_receive_pin), .drv_enable(drv_enable), .drv_dominant(drv_dominant),
	.wake_status_reg(wake_status_reg), .int_req(int_req), .chip_restart_req(chip_restart_req));
`default_nettype wire

// ---- test/test_lin_transceiver_mode_control.sv ----
// Testbench of the LIN mode control block with a bus model.
// Assumes short counts set through the block's parameters.
`timescale 1ns/1ps
`default_nettype none
module test_lin_transceiver_mode_control;
	import ltm_pkg::*;
	localparam int unsigned WK = 20;
	localparam int unsigned TO = 40;
	localparam int unsigned BT = 50;
	localparam int unsigned EN = 10;
	logic       clock, srst, mode_wr, cfg_wr, low_slope_wdata, fast_prog_wdata, spi_cs_n;
	logic       watchdog_on_bus_wake, watchdog_enabled, lin_transmit_in, bus_level;
	logic       supply_undervoltage, fault_clear, wake_clear, ev_ready, remote_dom;
	logic       lin_receive_pin, drv_enable, drv_dominant, low_slope_select, slope_ctrl_off;
	logic       lin_fault_flag, wake_status_reg, int_req, watchdog_enable_req;
	logic       chip_restart_req, ev_valid, t_v, r_v;
	ltm_chip_t  chip_mode;
	ltm_mode_t  mode_wdata, lin_mode_field;
	ltm_event_t ev_data;
	int         error_cnt = 0, n_compared = 0, n_int = 0, n_wd = 0, n_rst = 0, n_wev = 0;

	ltm_lin_ctrl #(.WAKE_CYC(WK), .TXTO_CYC(TO), .BUSTO_CYC(BT), .ENABLE_CNT(EN)) DUT (
		.clock, .srst, .chip_mode, .mode_wr, .mode_wdata, .cfg_wr, .low_slope_wdata,
		.fast_prog_wdata, .spi_cs_n, .watchdog_on_bus_wake, .watchdog_enabled,
		.lin_transmit_in, .bus_level, .supply_undervoltage, .fault_clear, .wake_clear,
		.ev_ready, .lin_mode_field, .lin_receive_pin, .drv_enable, .drv_dominant,
		.low_slope_select, .slope_ctrl_off, .lin_fault_flag, .wake_status_reg, .int_req,
		.watchdog_enable_req, .chip_restart_req, .ev_valid, .ev_data);
	ltm_bus_model u_bus (.drv_enable, .drv_dominant, .remote_dom, .bus_level);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// ----------------------------------------
	// Pulse counters and event sink
	// ----------------------------------------
	always @(posedge clock) begin
		n_int += (int_req === 1'b1);
		n_wd += (watchdog_enable_req === 1'b1);
		n_rst += (chip_restart_req === 1'b1);
		n_wev += (ev_valid === 1'b1 && ev_ready === 1'b1 && ev_data.kind === LTM_EV_WAKE);
		ev_ready <= 1'($urandom % 2);
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic exp_bus(input logic t, input logic r);
		return !(!t || r);
	endfunction : exp_bus
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task check_bit(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : check_bit
	task check_mode(input ltm_mode_t got, input ltm_mode_t exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: mode field %0d", $time, got);
		end
	endtask : check_mode
	task check_cnt(input int got, input int exp, input string what);
		check_bit(1'(got == exp), 1'b1, what);
	endtask : check_cnt
	task set_mode(input ltm_mode_t m);
		@(posedge clock);
		mode_wr <= 1'b1;
		mode_wdata <= m;
		@(posedge clock);
		mode_wr <= 1'b0;
		cyc(3);
	endtask : set_mode
	task clear_flags;
		@(posedge clock);
		fault_clear <= 1'b1;
		wake_clear <= 1'b1;
		@(posedge clock);
		fault_clear <= 1'b0;
		wake_clear <= 1'b0;
	endtask : clear_flags
	task set_remote(input logic v, input int n);
		@(posedge clock);
		remote_dom <= v;
		cyc(n);
	endtask : set_remote
	task wake_burst;
		set_remote(1'b1, WK + 10);
		set_remote(1'b0, 3);
	endtask : wake_burst
	task results;
		$display("counts: %0d compared, %0d mismatches", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	initial begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		$display("mismatch at %0t: run too long", $time);
		results();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'ha7dd));
		{srst, lin_transmit_in, spi_cs_n, watchdog_on_bus_wake} = 4'hf;
		{mode_wr, cfg_wr, low_slope_wdata, fast_prog_wdata, watchdog_enabled} = 5'h00;
		{supply_undervoltage, fault_clear, wake_clear, remote_dom} = 4'h0;
		chip_mode = LTM_CHIP_NORMAL;
		mode_wdata = LTM_MODE_OFF;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		cyc(1);
		check_mode(lin_mode_field, LTM_MODE_OFF);
		check_bit(lin_receive_pin, 1'b1, "reset receive");
		check_bit(drv_enable, 1'b0, "reset driver");
		$display("test reset done");
		@(posedge clock);
		lin_transmit_in <= 1'b0; // early low
		set_mode(LTM_MODE_NORMAL);
		check_mode(lin_mode_field, LTM_MODE_NORMAL);
		cyc(EN + 8);
		check_bit(drv_dominant, 1'b0, "early low sent");
		@(posedge clock);
		lin_transmit_in <= 1'b1; // back to recessive
		cyc(3);
		t_v = 1'b1;
		for (int i = 0; i < 24; i++) begin
			t_v = (t_v && i > 0) ? 1'($urandom % 2) : 1'b1;
			r_v = 1'($urandom % 4 == 0);
			if (i == 1)
				{t_v, r_v} = 2'h0;
			@(posedge clock);
			lin_transmit_in <= t_v;
			remote_dom <= r_v;
			cyc(3);
			check_bit(drv_dominant, !t_v, "drive level");
			check_bit(lin_receive_pin, exp_bus(t_v, r_v), "receive level");
		end
		@(posedge clock);
		lin_transmit_in <= 1'b1;
		remote_dom <= 1'b0;
		$display("test normal traffic done");
		clear_flags();
		lin_transmit_in <= 1'b0;
		cyc(TO + 6);
		check_bit(drv_enable, 1'b0, "timeout driver");
		check_bit(lin_fault_flag, 1'b1, "timeout flag");
		check_mode(lin_mode_field, LTM_MODE_NORMAL);
		@(posedge clock);
		lin_transmit_in <= 1'b1;
		cyc(3);
		check_bit(drv_enable, 1'b1, "driver back");
		$display("test transmit timeout done");
		@(posedge clock);
		supply_undervoltage <= 1'b1;
		set_remote(1'b1, 3);
		check_bit(drv_enable, 1'b0, "uv driver");
		check_bit(lin_receive_pin, 1'b1, "uv receive");
		@(posedge clock);
		supply_undervoltage <= 1'b0;
		set_remote(1'b0, 3);
		check_bit(drv_enable, 1'b1, "uv resume");
		check_mode(lin_mode_field, LTM_MODE_NORMAL);
		$display("test undervoltage done");
		@(posedge clock);
		{spi_cs_n, cfg_wr, low_slope_wdata, fast_prog_wdata} <= 4'h7;
		@(posedge clock);
		cfg_wr <= 1'b0;
		cyc(3);
		check_bit(low_slope_select, 1'b0, "slope before select");
		@(posedge clock);
		spi_cs_n <= 1'b1;
		cyc(3);
		check_bit(low_slope_select, 1'b1, "low slope");
		check_bit(slope_ctrl_off, 1'b1, "fast programming");
		$display("test slope done");
		@(posedge clock);
		chip_mode <= LTM_CHIP_STOP;
		set_mode(LTM_MODE_RXONLY);
		check_mode(lin_mode_field, LTM_MODE_RXONLY);
		set_remote(1'b1, 3);
		check_bit(drv_enable, 1'b0, "rx only driver");
		check_bit(lin_receive_pin, 1'b0, "rx only receive");
		set_remote(1'b0, 1);
		@(posedge clock);
		chip_mode <= LTM_CHIP_SLEEP;
		set_mode(LTM_MODE_NORMAL);
		check_mode(lin_mode_field, LTM_MODE_RXONLY);
		$display("test receive only done");
		@(posedge clock);
		chip_mode <= LTM_CHIP_NORMAL;
		set_mode(LTM_MODE_OFF);
		clear_flags();
		set_remote(1'b1, BT + 6);
		check_bit(wake_status_reg, 1'b0, "off wake");
		check_bit(lin_receive_pin, 1'b1, "off receive");
		check_bit(lin_fault_flag, 1'b1, "bus clamp");
		check_mode(lin_mode_field, LTM_MODE_OFF);
		set_remote(1'b0, 1);
		$display("test off and clamp done");
		@(posedge clock);
		chip_mode <= LTM_CHIP_STOP;
		set_mode(LTM_MODE_WAKE);
		clear_flags();
		wake_burst();
		check_cnt(n_int, 1, "stop interrupt");
		check_cnt(n_wd, 1, "watchdog request");
		check_cnt(n_rst, 0, "stop restart");
		check_bit(wake_status_reg, 1'b1, "wake flag");
		check_bit(lin_receive_pin, 1'b0, "wake hold");
		check_mode(lin_mode_field, LTM_MODE_WAKE);
		wake_burst();
		check_cnt(n_int, 1, "not rearmed");
		@(posedge clock);
		chip_mode <= LTM_CHIP_SLEEP;
		cyc(3);
		wake_burst();
		check_cnt(n_rst, 1, "sleep restart");
		check_cnt(n_int, 1, "sleep interrupt");
		@(posedge clock);
		chip_mode <= LTM_CHIP_NORMAL;
		set_mode(LTM_MODE_OFF);
		check_bit(lin_receive_pin, 1'b1, "hold released");
		set_mode(LTM_MODE_WAKE);
		wake_burst();
		check_cnt(n_int, 2, "rearmed");
		check_cnt(n_wd, 1, "no normal watchdog");
		set_mode(LTM_MODE_OFF);
		@(posedge clock);
		chip_mode <= LTM_CHIP_FAILSAFE;
		cyc(3);
		check_mode(lin_mode_field, LTM_MODE_WAKE);
		wake_burst();
		check_cnt(n_rst, 2, "fail-safe restart");
		check_cnt(n_int, 2, "fail-safe interrupt");
		check_bit(lin_receive_pin, 1'b0, "fail-safe receive");
		cyc(40);
		check_cnt(n_wev, 4, "wake records");
		$display("test wake done");
		results();
	end
endmodule : test_lin_transceiver_mode_control
`default_nettype wire
